// >>> hdl/ibq_regs.vh
// register map, field codes and reset values of the image block transfer queue
`ifndef IBQ_REGS_VH
`define IBQ_REGS_VH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define IBQ_OFF_METHOD     8'h00
`define IBQ_OFF_RUN_STYLE  8'h04
`define IBQ_OFF_BLOCKS     8'h08
`define IBQ_OFF_CAPACITY   8'h0c
`define IBQ_OFF_FILL       8'h10
`define IBQ_OFF_LOST       8'h14
`define IBQ_OFF_DISCIPLINE 8'h18
`define IBQ_OFF_CMD        8'h1c
`define IBQ_OFF_CHAN       8'h20
`define IBQ_OFF_STATUS     8'h24
`define IBQ_OFF_IRQ_STAT   8'h28
`define IBQ_OFF_IRQ_CLR    8'h2c
`define IBQ_OFF_IRQ_EN     8'h30

// ****************************************************************
// field codes
// ****************************************************************
`define IBQ_METHOD_BASIC   2'h0
`define IBQ_METHOD_AUTO    2'h1
`define IBQ_METHOD_HOST    2'h2
`define IBQ_METHOD_BAD     2'h3
`define IBQ_STYLE_CONT     1'b0
`define IBQ_STYLE_FIXED    1'b1
`define IBQ_ORDER_OLDEST   2'h0
`define IBQ_CMD_BEGIN_BIT  0
`define IBQ_CMD_HALT_BIT   1
`define IBQ_CHAN_OPEN_BIT  0
`define IBQ_EV_LOST        0
`define IBQ_EV_RUN_DONE    1
`define IBQ_EV_SENT        2
`define IBQ_NUM_EV         3

// ****************************************************************
// sizes and reset values
// ****************************************************************
`define IBQ_BLK_W          32
`define IBQ_DEPTH          8
`define IBQ_PTR_W          3
`define IBQ_CNT_W          4
`define IBQ_CAPACITY       4'h8
`define IBQ_BPR_W          16
`define IBQ_RST_METHOD     2'h0
`define IBQ_RST_BLOCKS     16'h0001
`define IBQ_RST_CHAN_OPEN  1'b1
`define IBQ_RESP_OKAY      2'h0
`define IBQ_RESP_SLVERR    2'h2

`endif

// >>> hdl/ibq_mem.v
// block storage of the transfer queue, one write port and one registered read port
`include "ibq_regs.vh"

module ibq_mem (
	input wire aclk,
	input wire wr_en,
	input wire [`IBQ_PTR_W-1:0] wr_addr,
	input wire [`IBQ_BLK_W-1:0] wr_data,
	input wire rd_en,
	input wire [`IBQ_PTR_W-1:0] rd_addr,
	output reg [`IBQ_BLK_W-1:0] rd_data_q
);

	reg [`IBQ_BLK_W-1:0] store [0:`IBQ_DEPTH-1];

	// read-first: a read of the slot being overwritten returns the old block
	always @(posedge aclk) begin
		if (wr_en) begin
			store[wr_addr] <= wr_data;
		end
		if (rd_en) begin
			rd_data_q <= store[rd_addr];
		end
	end

endmodule // ibq_mem

// >>> hdl/ibq_top.v
// image block transfer queue with run control, loss counting and axi4-lite registers
`include "ibq_regs.vh"

// Overview of operation
// - basic and automatic send queued blocks at once
// - method select: basic, automatic, host driven
// - run style select: continuous or fixed count
// - continuous: begin and halt gate streaming
// - fixed count: send configured blocks, then stop
// - blocks per run used only in fixed count
// - queue capacity readable, read only
// - fill level tracks every push and pop
// - lost block counter counts overwritten blocks
// - queue discipline writable, only oldest first
// - begin command starts streaming of queued blocks
// - halt finishes current block, then stops
// - full queue drops oldest unsent, counts loss
// - acquisition start or stop changes nothing here
// - closing channel empties queue, cancels sends
module ibq_top (
	input wire aclk,
	input wire aresetn,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire blk_in_valid,
	input wire [`IBQ_BLK_W-1:0] blk_in_data,
	output reg strm_tvalid_q,
	output reg [`IBQ_BLK_W-1:0] strm_tdata_q,
	input wire strm_tready,
	output reg irq_q
);

	// ****************************************************************
	// state
	// ****************************************************************
	reg aw_got_q;
	reg w_got_q;
	reg [7:0] awaddr_q;
	reg [31:0] wdata_q;
	reg [3:0] wstrb_q;
	reg [1:0] xfer_method_select_q;
	reg xfer_run_style_q;
	reg [`IBQ_BPR_W-1:0] blocks_per_run_q;
	reg [1:0] queue_discipline_q;
	reg chan_open_q;
	reg [`IBQ_NUM_EV-1:0] irq_en_q;
	reg [`IBQ_NUM_EV-1:0] irq_stat_q;
	reg [`IBQ_PTR_W-1:0] head_q;
	reg [`IBQ_PTR_W-1:0] tail_q;
	reg [`IBQ_CNT_W-1:0] queue_fill_level_q;
	reg [31:0] lost_block_counter_q;
	reg stream_on_q;
	reg [`IBQ_BPR_W-1:0] run_left_q;
	reg fetch_q;
	reg [31:0] rd_mux;
	reg rd_ok;
	wire [`IBQ_BLK_W-1:0] mem_rd_data;

	// merge new write data into an old word under the byte strobes
	function [31:0] ibq_merge;
		input [31:0] old_val;
		input [31:0] new_val;
		input [3:0] strb;
		integer i;
		begin
			for (i = 0; i < 4; i = i + 1) begin
				ibq_merge[i*8 +: 8] = strb[i] ? new_val[i*8 +: 8] : old_val[i*8 +: 8];
			end
		end
	endfunction

	// ****************************************************************
	// write decode and commands
	// ****************************************************************
	wire wr_fire = aw_got_q & w_got_q & ~s_axi_bvalid;
	wire [31:0] wr_word = ibq_merge(32'h0000_0000, wdata_q, wstrb_q);
	// byte lanes enabled by the strobes, kept as a net so it can be sliced
	wire [31:0] wr_mask = ibq_merge(32'h0000_0000, 32'hffff_ffff, wstrb_q);
	wire host_mode = (xfer_method_select_q == `IBQ_METHOD_HOST);
	wire fixed_style = (xfer_run_style_q == `IBQ_STYLE_FIXED);
	// commands count only in the host driven method; elsewhere they are dropped
	wire cmd_begin = wr_fire & (awaddr_q == `IBQ_OFF_CMD) & host_mode
		& wr_word[`IBQ_CMD_BEGIN_BIT];
	wire cmd_halt = wr_fire & (awaddr_q == `IBQ_OFF_CMD) & host_mode
		& wr_word[`IBQ_CMD_HALT_BIT];
	// a write of zero to the open bit closes the channel
	wire chan_close = wr_fire & (awaddr_q == `IBQ_OFF_CHAN) & wstrb_q[0]
		& ~wdata_q[`IBQ_CHAN_OPEN_BIT] & chan_open_q;

	// ****************************************************************
	// queue pointers and loss accounting
	// ****************************************************************
	// basic and automatic stream whenever a block is queued
	wire allow = chan_open_q & (~host_mode | (fixed_style ? (run_left_q != 0) : stream_on_q));
	wire q_empty = (queue_fill_level_q == 0);
	wire q_full = (queue_fill_level_q == `IBQ_CAPACITY);
	// pop only when the output slot is free, so one block is in flight at most
	wire pop = allow & ~q_empty & ~fetch_q & ~strm_tvalid_q & ~chan_close;
	// acquisition state never enters here, so it cannot disturb the queue
	wire push = blk_in_valid & chan_open_q & ~chan_close;
	// full with no pop: overwrite the oldest unsent block
	wire drop = push & q_full & ~pop;
	wire sent = strm_tvalid_q & strm_tready;
	wire run_done = pop & host_mode & fixed_style & (run_left_q == 1);
	wire [`IBQ_NUM_EV-1:0] events;

	assign events[`IBQ_EV_LOST] = drop;
	assign events[`IBQ_EV_RUN_DONE] = run_done;
	assign events[`IBQ_EV_SENT] = sent;

	// oldest block always leaves first; head is the oldest, tail the next slot to write
	always @(posedge aclk) begin
		if (!aresetn) begin
			head_q <= {`IBQ_PTR_W{1'b0}};
			tail_q <= {`IBQ_PTR_W{1'b0}};
			queue_fill_level_q <= {`IBQ_CNT_W{1'b0}};
			lost_block_counter_q <= 32'h0000_0000;
		end else if (chan_close) begin
			head_q <= {`IBQ_PTR_W{1'b0}};
			tail_q <= {`IBQ_PTR_W{1'b0}};
			queue_fill_level_q <= {`IBQ_CNT_W{1'b0}};
		end else begin
			if (push) begin
				tail_q <= tail_q + 1'b1;
			end
			if (pop | drop) begin
				head_q <= head_q + 1'b1;
			end
			// a drop keeps the level: one block in, one block out
			if ((push & ~drop) & ~pop) begin
				queue_fill_level_q <= queue_fill_level_q + 1'b1;
			end else if (pop & ~push) begin
				queue_fill_level_q <= queue_fill_level_q - 1'b1;
			end
			if (drop) begin
				lost_block_counter_q <= lost_block_counter_q + 32'h0000_0001;
			end
		end
	end

	ibq_mem u_mem (
		.aclk(aclk),
		.wr_en(push),
		.wr_addr(tail_q),
		.wr_data(blk_in_data),
		.rd_en(pop),
		.rd_addr(head_q),
		.rd_data_q(mem_rd_data)
	);

	// ****************************************************************
	// run control
	// ****************************************************************
	always @(posedge aclk) begin
		if (!aresetn) begin
			stream_on_q <= 1'b0;
			run_left_q <= {`IBQ_BPR_W{1'b0}};
		end else if (chan_close) begin
			stream_on_q <= 1'b0;
			run_left_q <= {`IBQ_BPR_W{1'b0}};
		end else if (cmd_halt) begin
			// the block already fetched or on the stream still completes
			stream_on_q <= 1'b0;
			run_left_q <= {`IBQ_BPR_W{1'b0}};
		end else if (cmd_begin) begin
			if (fixed_style) begin
				run_left_q <= blocks_per_run_q;
			end else begin
				stream_on_q <= 1'b1;
			end
		end else if (pop & host_mode & fixed_style) begin
			// reaching zero leaves the run idle until the next begin
			run_left_q <= run_left_q - 1'b1;
		end
	end

	// ****************************************************************
	// stream output
	// ****************************************************************
	// memory read data lands one cycle after the pop, then waits for tready
	always @(posedge aclk) begin
		if (!aresetn) begin
			fetch_q <= 1'b0;
			strm_tvalid_q <= 1'b0;
			strm_tdata_q <= {`IBQ_BLK_W{1'b0}};
		end else if (chan_close) begin
			// a closed channel takes back even the offered block
			fetch_q <= 1'b0;
			strm_tvalid_q <= 1'b0;
		end else begin
			fetch_q <= pop;
			if (fetch_q) begin
				strm_tvalid_q <= 1'b1;
				strm_tdata_q <= mem_rd_data;
			end else if (sent) begin
				strm_tvalid_q <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// interrupt status, set wins over clear
	// ****************************************************************
	wire irq_clr_hit = wr_fire & (awaddr_q == `IBQ_OFF_IRQ_CLR);

	genvar g;
	generate
		for (g = 0; g < `IBQ_NUM_EV; g = g + 1) begin : g_irq
			always @(posedge aclk) begin
				if (!aresetn) begin
					irq_stat_q[g] <= 1'b0;
				end else if (events[g]) begin
					irq_stat_q[g] <= 1'b1;
				end else if (irq_clr_hit & wr_word[g]) begin
					irq_stat_q[g] <= 1'b0;
				end
			end
		end
	endgenerate

	always @(posedge aclk) begin
		if (!aresetn) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(irq_stat_q & irq_en_q);
		end
	end

	// ****************************************************************
	// axi4-lite write channel and register writes
	// ****************************************************************
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `IBQ_RESP_OKAY;
		end else begin
			// ready rises the cycle after the channel is free again
			s_axi_awready <= ~aw_got_q & ~(s_axi_awvalid & s_axi_awready) & ~s_axi_bvalid;
			s_axi_wready <= ~w_got_q & ~(s_axi_wvalid & s_axi_wready) & ~s_axi_bvalid;
			if (s_axi_awvalid & s_axi_awready) begin
				aw_got_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid & s_axi_wready) begin
				w_got_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_got_q <= 1'b0;
				w_got_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				if ((awaddr_q == `IBQ_OFF_METHOD) || (awaddr_q == `IBQ_OFF_RUN_STYLE)
					|| (awaddr_q == `IBQ_OFF_BLOCKS) || (awaddr_q == `IBQ_OFF_DISCIPLINE)
					|| (awaddr_q == `IBQ_OFF_CMD) || (awaddr_q == `IBQ_OFF_CHAN)
					|| (awaddr_q == `IBQ_OFF_IRQ_CLR) || (awaddr_q == `IBQ_OFF_IRQ_EN)
					|| (awaddr_q == `IBQ_OFF_CAPACITY) || (awaddr_q == `IBQ_OFF_FILL)
					|| (awaddr_q == `IBQ_OFF_LOST) || (awaddr_q == `IBQ_OFF_STATUS)
					|| (awaddr_q == `IBQ_OFF_IRQ_STAT)) begin
					s_axi_bresp <= `IBQ_RESP_OKAY;
				end else begin
					s_axi_bresp <= `IBQ_RESP_SLVERR;
				end
			end else if (s_axi_bvalid & s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// writable settings; read-only offsets absorb writes silently
	always @(posedge aclk) begin
		if (!aresetn) begin
			xfer_method_select_q <= `IBQ_RST_METHOD;
			xfer_run_style_q <= `IBQ_STYLE_CONT;
			blocks_per_run_q <= `IBQ_RST_BLOCKS;
			queue_discipline_q <= `IBQ_ORDER_OLDEST;
			chan_open_q <= `IBQ_RST_CHAN_OPEN;
			irq_en_q <= {`IBQ_NUM_EV{1'b0}};
		end else if (wr_fire) begin
			if ((awaddr_q == `IBQ_OFF_METHOD) && wstrb_q[0]) begin
				// the unused fourth code is refused, the old method stays
				if (wdata_q[1:0] != `IBQ_METHOD_BAD) begin
					xfer_method_select_q <= wdata_q[1:0];
				end
			end else if ((awaddr_q == `IBQ_OFF_RUN_STYLE) && wstrb_q[0]) begin
				xfer_run_style_q <= wdata_q[0];
			end else if (awaddr_q == `IBQ_OFF_BLOCKS) begin
				// stored always, but only a fixed count begin ever reads it
				blocks_per_run_q <= wr_word[`IBQ_BPR_W-1:0]
					| (blocks_per_run_q & ~wr_mask[`IBQ_BPR_W-1:0]);
			end else if ((awaddr_q == `IBQ_OFF_DISCIPLINE) && wstrb_q[0]) begin
				// oldest first is the one order; other codes leave it unchanged
				if (wdata_q[1:0] == `IBQ_ORDER_OLDEST) begin
					queue_discipline_q <= wdata_q[1:0];
				end
			end else if ((awaddr_q == `IBQ_OFF_CHAN) && wstrb_q[0]) begin
				chan_open_q <= wdata_q[`IBQ_CHAN_OPEN_BIT];
			end else if ((awaddr_q == `IBQ_OFF_IRQ_EN) && wstrb_q[0]) begin
				irq_en_q <= wdata_q[`IBQ_NUM_EV-1:0];
			end
		end
	end

	// ****************************************************************
	// axi4-lite read channel
	// ****************************************************************
	// reads have no side effects, so the mux can sit right on araddr
	always @* begin
		rd_mux = 32'h0000_0000;
		rd_ok = 1'b1;
		if (s_axi_araddr == `IBQ_OFF_METHOD) begin
			rd_mux[1:0] = xfer_method_select_q;
		end else if (s_axi_araddr == `IBQ_OFF_RUN_STYLE) begin
			rd_mux[0] = xfer_run_style_q;
		end else if (s_axi_araddr == `IBQ_OFF_BLOCKS) begin
			rd_mux[`IBQ_BPR_W-1:0] = blocks_per_run_q;
		end else if (s_axi_araddr == `IBQ_OFF_CAPACITY) begin
			rd_mux[`IBQ_CNT_W-1:0] = `IBQ_CAPACITY;
		end else if (s_axi_araddr == `IBQ_OFF_FILL) begin
			rd_mux[`IBQ_CNT_W-1:0] = queue_fill_level_q;
		end else if (s_axi_araddr == `IBQ_OFF_LOST) begin
			rd_mux = lost_block_counter_q;
		end else if (s_axi_araddr == `IBQ_OFF_DISCIPLINE) begin
			rd_mux[1:0] = queue_discipline_q;
		end else if ((s_axi_araddr == `IBQ_OFF_CMD) || (s_axi_araddr == `IBQ_OFF_IRQ_CLR)) begin
			rd_mux = 32'h0000_0000;
		end else if (s_axi_araddr == `IBQ_OFF_CHAN) begin
			rd_mux[`IBQ_CHAN_OPEN_BIT] = chan_open_q;
		end else if (s_axi_araddr == `IBQ_OFF_STATUS) begin
			rd_mux = {run_left_q, 12'h000, strm_tvalid_q, chan_open_q, allow, stream_on_q};
		end else if (s_axi_araddr == `IBQ_OFF_IRQ_STAT) begin
			rd_mux[`IBQ_NUM_EV-1:0] = irq_stat_q;
		end else if (s_axi_araddr == `IBQ_OFF_IRQ_EN) begin
			rd_mux[`IBQ_NUM_EV-1:0] = irq_en_q;
		end else begin
			rd_ok = 1'b0;
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `IBQ_RESP_OKAY;
		end else begin
			s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
			if (s_axi_arvalid & s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_mux;
				s_axi_rresp <= rd_ok ? `IBQ_RESP_OKAY : `IBQ_RESP_SLVERR;
			end else if (s_axi_rvalid & s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule // ibq_top

// >>> verif/ibq_props.sv
// concurrent checks on the ports of the image block transfer queue
`include "ibq_regs.vh"

module ibq_props (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic strm_tvalid_q,
	input wire logic [`IBQ_BLK_W-1:0] strm_tdata_q,
	input wire logic strm_tready
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************************************
	// bus and stream relations
	// ****************************************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// both halves of a write taken at one edge, as the bench offers them
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	// a block offered but not yet accepted
	sequence offer_stalled;
		strm_tvalid_q && !strm_tready;
	endsequence

	write_answer_a: assert property (wr_taken |-> ##2 s_axi_bvalid)
		else $error("write response not on time");
	aw_block_a: assert property (wr_taken |=> !s_axi_awready [*2])
		else $error("second write address accepted too early");
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data not on time");
	read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address accepted while data pending");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before taken");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped before taken");
	// only a channel close, whose write response rises at that edge, may retract
	offer_hold_a: assert property (offer_stalled |=>
		(strm_tvalid_q && $stable(strm_tdata_q)) || $rose(s_axi_bvalid))
		else $error("offered block changed before accepted");
	send_gap_a: assert property (strm_tvalid_q && strm_tready |=> !strm_tvalid_q)
		else $error("block offered again right after handshake");
endmodule // ibq_props

// >>> verif/ibq_host_sink.sv
// host side stream receiver that can stall or accept slowly
module ibq_host_sink (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic stall,
	input wire logic slow,
	input wire logic strm_tvalid_q,
	input wire logic [31:0] strm_tdata_q,
	output logic strm_tready,
	output logic [31:0] rx_count
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] rx_mem [0:63];
	logic tog_q;

	// ready does not wait for valid; slow mode accepts every other cycle
	always @(posedge aclk) begin
		if (!aresetn) begin
			strm_tready <= 1'b0;
			rx_count <= 32'h0;
			tog_q <= 1'b0;
		end else begin
			tog_q <= ~tog_q;
			strm_tready <= !stall && (!slow || tog_q);
			if (strm_tvalid_q && strm_tready) begin
				rx_mem[rx_count[5:0]] <= strm_tdata_q;
				rx_count <= rx_count + 32'h1;
			end
		end
	end
endmodule // ibq_host_sink

// >>> verif/ibq_top_tb.sv
// self-checking bench of the transfer queue: register tasks and stream scenarios
`include "ibq_regs.vh"

module ibq_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk, aresetn, stall, slow;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, blk_in_data, d;
	logic [3:0] s_axi_wstrb;
	logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic blk_in_valid, r_err, b_err;
	wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire logic [1:0] s_axi_bresp, s_axi_rresp;
	wire logic [31:0] s_axi_rdata, strm_tdata_q, rx_count;
	wire logic strm_tvalid_q, strm_tready, irq_q;
	int failures = 0;
	int checks_done = 0;

	ibq_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .blk_in_valid(blk_in_valid), .blk_in_data(blk_in_data),
		.strm_tvalid_q(strm_tvalid_q), .strm_tdata_q(strm_tdata_q),
		.strm_tready(strm_tready), .irq_q(irq_q));
	ibq_host_sink u_host (.aclk(aclk), .aresetn(aresetn), .stall(stall), .slow(slow),
		.strm_tvalid_q(strm_tvalid_q), .strm_tdata_q(strm_tdata_q),
		.strm_tready(strm_tready), .rx_count(rx_count));

	// ****************************************************************
	// clock, watchdog and shared tasks
	// ****************************************************************
	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end
	// the scenarios need a few hundred cycles; this leaves a wide margin
	initial begin
		#400000;
		failures++;
		end_sim();
	end
	task automatic end_sim();
		if (failures == 0 && checks_done > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// each bus and block task opens with an edge so no strobe is driven twice in one step
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic aw, w;
		aw = 1'b0;
		w = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw && w)) begin
			@(posedge aclk);
			if (!aw && s_axi_awready) begin
				aw = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w && s_axi_wready) begin
				w = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		while (!s_axi_bvalid) @(posedge aclk);
		b_err = (s_axi_bresp === `IBQ_RESP_SLVERR);
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		while (!s_axi_rvalid) @(posedge aclk);
		d = s_axi_rdata;
		r_err = (s_axi_rresp === `IBQ_RESP_SLVERR);
		s_axi_rready <= 1'b0;
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		rd(a);
		chk(d, exp);
	endtask
	task automatic push(input int n);
		@(posedge aclk);
		blk_in_valid <= 1'b1;
		blk_in_data <= 32'hb10c_0000 + n;
		@(posedge aclk);
		blk_in_valid <= 1'b0;
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge aclk);
	endtask
	// received count, then the payload of block slot idx
	task automatic rx(input int n, input int idx, input int blk);
		repeat (300) if (rx_count < n) @(posedge aclk);
		chk(rx_count, n);
		chk(u_host.rx_mem[idx], 32'hb10c_0000 + blk);
	endtask

	// ****************************************************************
	// scenarios
	// ****************************************************************
	initial begin
		{aresetn, stall, slow, blk_in_valid, s_axi_awvalid, s_axi_wvalid} = '0;
		{s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, blk_in_data} = '0;
		s_axi_wstrb = 4'hf;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rdchk(`IBQ_OFF_METHOD, 32'h0);
		chk(r_err, 1'b0);
		rdchk(`IBQ_OFF_RUN_STYLE, 32'h0);
		rdchk(`IBQ_OFF_BLOCKS, 32'h1);
		wr(`IBQ_OFF_CAPACITY, 32'h3);
		chk(b_err, 1'b0);
		rdchk(`IBQ_OFF_CAPACITY, 32'h8);
		wr(`IBQ_OFF_DISCIPLINE, 32'h1);
		rdchk(`IBQ_OFF_DISCIPLINE, 32'h0);
		rdchk(8'h40, 32'h0);
		chk(r_err, 1'b1);
		wr(8'h40, 32'h1);
		chk(b_err, 1'b1);
		for (int i = 0; i < 4; i++) begin
			wr(`IBQ_OFF_METHOD, i);
			rdchk(`IBQ_OFF_METHOD, (i == 3) ? 2 : i);
		end
		for (int i = 1; i >= 0; i--) begin
			wr(`IBQ_OFF_RUN_STYLE, i);
			rdchk(`IBQ_OFF_RUN_STYLE, i);
		end
		// basic: halt ignored, block sent at once, interrupt raised and cleared
		wr(`IBQ_OFF_METHOD, 32'h0);
		wr(`IBQ_OFF_IRQ_EN, 32'h4);
		wr(`IBQ_OFF_CMD, 32'h2);
		push(1);
		rx(1, 0, 1);
		idle(3);
		chk(irq_q, 1'b1);
		wr(`IBQ_OFF_IRQ_CLR, 32'h4);
		rdchk(`IBQ_OFF_IRQ_STAT, 32'h0);
		chk(irq_q, 1'b0);
		wr(`IBQ_OFF_IRQ_EN, 32'h0);
		push(2);
		rx(2, 1, 2);
		rdchk(`IBQ_OFF_IRQ_STAT, 32'h4);
		chk(irq_q, 1'b0);
		// automatic with a stalled host: overflow drops the oldest unsent block
		wr(`IBQ_OFF_METHOD, 32'h1);
		stall <= 1'b1;
		for (int i = 0; i < 10; i++) push(16 + i);
		rdchk(`IBQ_OFF_FILL, 32'h8);
		rdchk(`IBQ_OFF_LOST, 32'h1);
		stall <= 1'b0;
		slow <= 1'b1;
		rx(3, 2, 16);
		for (int i = 0; i < 8; i++) rx(4 + i, 3 + i, 18 + i);
		rdchk(`IBQ_OFF_FILL, 32'h0);
		rdchk(`IBQ_OFF_IRQ_STAT, 32'h5);
		wr(`IBQ_OFF_IRQ_CLR, 32'h7);
		// host driven continuous: nothing until begin, count setting ignored
		wr(`IBQ_OFF_METHOD, 32'h2);
		push(40);
		idle(20);
		chk(rx_count, 32'd11);
		wr(`IBQ_OFF_CMD, 32'h1);
		rx(12, 11, 40);
		for (int i = 0; i < 3; i++) push(41 + i);
		rx(15, 14, 43);
		// halt while a block is offered: that block completes, then no more
		stall <= 1'b1;
		push(44);
		push(45);
		idle(10);
		wr(`IBQ_OFF_CMD, 32'h2);
		stall <= 1'b0;
		rx(16, 15, 44);
		idle(20);
		chk(rx_count, 32'd16);
		// fixed count of two, then idle until the next begin
		wr(`IBQ_OFF_RUN_STYLE, 32'h1);
		wr(`IBQ_OFF_BLOCKS, 32'h2);
		push(46);
		push(47);
		wr(`IBQ_OFF_CMD, 32'h1);
		rx(18, 17, 46);
		idle(20);
		chk(rx_count, 32'd18);
		rdchk(`IBQ_OFF_STATUS, 32'h4);
		rdchk(`IBQ_OFF_FILL, 32'h1);
		rdchk(`IBQ_OFF_IRQ_STAT, 32'h6);
		wr(`IBQ_OFF_CMD, 32'h1);
		rx(19, 18, 47);
		// closing the channel flushes queued and offered blocks
		wr(`IBQ_OFF_RUN_STYLE, 32'h0);
		wr(`IBQ_OFF_CMD, 32'h1);
		stall <= 1'b1;
		for (int i = 0; i < 3; i++) push(48 + i);
		idle(10);
		wr(`IBQ_OFF_CHAN, 32'h0);
		chk(strm_tvalid_q, 1'b0);
		rdchk(`IBQ_OFF_FILL, 32'h0);
		rdchk(`IBQ_OFF_LOST, 32'h1);
		wr(`IBQ_OFF_CHAN, 32'h1);
		stall <= 1'b0;
		idle(20);
		chk(rx_count, 32'd19);
		end_sim();
	end
endmodule // ibq_top_tb

bind ibq_top ibq_props u_props (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.strm_tvalid_q(strm_tvalid_q), .strm_tdata_q(strm_tdata_q),
	.strm_tready(strm_tready));
